// *** core/pibad_pkg.sv ***
// Purpose: shared constants and carriers for the base register and I/O window decode
// Assumes: config offsets are byte offsets into the type 0 header
// Notes:   window sizes are log2 of bytes
package pibad_pkg;

  // config header slots for base registers
  localparam logic [7:0]  PIBAD_BAR_FIRST_OFF  = 8'h10;
  localparam logic [7:0]  PIBAD_BAR_DEV_OFF    = 8'h14;
  localparam logic [7:0]  PIBAD_BAR_MEM_OFF    = 8'h18;
  localparam int          PIBAD_BAR_SLOTS      = 6;
  localparam logic [5:0]  PIBAD_BAR_FIRST_DW   = 6'h04;
  localparam logic [5:0]  PIBAD_BAR_LAST_DW    = 6'h09;

  // window sizes
  localparam int          PIBAD_IO_WIN_LOG2    = 6;
  localparam int          PIBAD_MEM_WIN_LOG2   = 6;
  localparam int          PIBAD_IO_MIN_LOG2    = 2;
  localparam int          PIBAD_MEM_MIN_LOG2   = 4;
  localparam int          PIBAD_ADDR_W         = 32;

  // read-only low fields of a base register
  localparam logic        PIBAD_SPACE_IO       = 1'b1;
  localparam logic        PIBAD_SPACE_MEM      = 1'b0;
  localparam logic [1:0]  PIBAD_MEM_TYPE_32    = 2'b00;
  localparam logic        PIBAD_PREFETCH_OFF   = 1'b0;
  localparam logic [31:0] PIBAD_BAR_RST        = 32'h0000_0000;

  // lane layout inside the aliased longword
  localparam int          PIBAD_CSR_SEL_BIT    = 1;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  offset;
    logic [3:0]  be;
    logic [31:0] wdata;
  } pibad_cfg_req_type;

  typedef struct packed {
    logic        valid;
    logic        owned;
    logic [31:0] rdata;
  } pibad_cfg_rsp_type;

  typedef struct packed {
    logic        valid;
    logic        is_io;
    logic        is_mem;
    logic [31:0] addr;
  } pibad_addr_req_type;

  typedef struct packed {
    logic        valid;
    logic        io_hit;
    logic        mem_hit;
    logic        csr_sel;
    logic [1:0]  lane;
  } pibad_claim_type;

endpackage : pibad_pkg

// *** core/pibad_bar.sv ***
// Purpose: one 32-bit base register with size mask and address match
// Assumes: write strobe already qualified by slot select and clock enable
// Notes:   only bits at and above SIZE_LOG2 are stored
`timescale 1ns/1ps
`default_nettype none
module pibad_bar
  import pibad_pkg::*;
#(
  parameter bit IS_IO     = 1'b1,
  parameter int SIZE_LOG2 = PIBAD_IO_WIN_LOG2,
  parameter bit PREFETCH  = PIBAD_PREFETCH_OFF
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        wr_en,
  input  wire logic [3:0]  be,
  input  wire logic [31:0] wdata,
  input  wire logic [31:0] addr,
  output logic      [31:0] rdata,
  output logic      [31:0] base,
  output logic             match
);

  localparam logic [31:0] ADDR_MASK = ~((32'h0000_0001 << SIZE_LOG2) - 32'h0000_0001);

  generate
    if (SIZE_LOG2 < PIBAD_IO_MIN_LOG2 || SIZE_LOG2 > 31) begin : g_bad_size
      $error("pibad_bar: SIZE_LOG2 out of range");
    end
  endgenerate

  logic [31:0] base_r;
  logic [31:0] base_nxt;
  wire  [31:0] lane_mask;
  wire  [31:0] wr_mask;
  wire  [3:0]  low_field;

  assign lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  assign wr_mask   = lane_mask & ADDR_MASK;
  assign base_nxt  = (base_r & ~wr_mask) | (wdata & wr_mask);

  // read-only low bits: space indicator, type, prefetch
  assign low_field = IS_IO ? {2'b00, 1'b0, PIBAD_SPACE_IO}
                           : {PREFETCH, PIBAD_MEM_TYPE_32, PIBAD_SPACE_MEM};

  // don't-care address bits read zero so sizing reveals the window
  assign rdata = (base_r & ADDR_MASK) | {28'h000_0000, low_field};

  assign base  = base_r;
  // natural alignment: compare only bits above the window
  assign match = ((addr & ADDR_MASK) == (base_r & ADDR_MASK));

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      base_r <= PIBAD_BAR_RST;
    end else if (ce && wr_en) begin
      base_r <= base_nxt;
    end
  end

endmodule : pibad_bar
`default_nettype wire

// *** core/pibad_top.sv ***
// Overview of operation
// - store only upper bits matching claimed size
// - all-ones write reads back size mask
// - ranges power of two, naturally aligned
// - recommended minimum claim sizes for spaces
// - unused part of range need not respond
// - six consecutive base register slots
// - first slot left to interface bridge
// - function registers behind second slot
// - I/O register claims 64-byte window
// - fifteen longwords alias first; decode bits 1:0
// - separate memory and I/O base registers
// - control functions also mappable in memory
// - flag prefetchable only for plain memory
// - bit 0 gives space; I/O bit 1 zero
// - memory type bits 00: 32-bit anywhere
// - upper bytes control/status, lower bytes data
//
// Purpose: base register config access and address claim for the board function
// Assumes: command register enables come from the config core; inputs synchronous to mclk
// Notes:   responses and claims are registered, one cycle after the request edge
`timescale 1ns/1ps
`default_nettype none
module pibad_top
  import pibad_pkg::*;
#(
  parameter int IO_SIZE_LOG2  = PIBAD_IO_WIN_LOG2,
  parameter int MEM_SIZE_LOG2 = PIBAD_MEM_WIN_LOG2,
  parameter bit MEM_BAR_EN    = 1'b1
) (
  input  wire logic               mclk,
  input  wire logic               rst_n,
  input  wire logic               ce,
  input  wire logic               io_space_en,
  input  wire logic               mem_space_en,
  input  wire pibad_cfg_req_type  cfg_req,
  output pibad_cfg_rsp_type       cfg_rsp,
  input  wire pibad_addr_req_type addr_req,
  output pibad_claim_type         claim,
  output logic [31:0]             io_base,
  output logic [31:0]             mem_base
);

  generate
    if (IO_SIZE_LOG2 != PIBAD_IO_WIN_LOG2 && IO_SIZE_LOG2 < PIBAD_IO_MIN_LOG2) begin : g_bad_io
      $error("pibad_top: I/O window too small");
    end
    if (MEM_SIZE_LOG2 < PIBAD_MEM_MIN_LOG2) begin : g_bad_mem
      $error("pibad_top: memory window too small");
    end
  endgenerate

  // ---- config offset decode
  wire  [5:0] cfg_dw;
  wire        cfg_in_bars;
  wire        sel_first;
  wire        sel_io;
  wire        sel_mem;
  wire        cfg_take;
  wire        cfg_wr;

  assign cfg_dw      = cfg_req.offset[7:2];
  // six doubleword slots starting at the first base register offset
  assign cfg_in_bars = (cfg_dw >= PIBAD_BAR_FIRST_DW) && (cfg_dw <= PIBAD_BAR_LAST_DW);
  // bridge owns the first slot; nothing of this function sits there
  assign sel_first   = cfg_in_bars && (cfg_req.offset[7:2] == PIBAD_BAR_FIRST_OFF[7:2]);
  assign sel_io      = cfg_in_bars && (cfg_req.offset[7:2] == PIBAD_BAR_DEV_OFF[7:2]);
  // each 32-bit register takes one slot, so the memory one follows directly
  assign sel_mem     = MEM_BAR_EN && cfg_in_bars
                       && (cfg_req.offset[7:2] == PIBAD_BAR_MEM_OFF[7:2]);
  assign cfg_take    = ce && cfg_req.valid;
  assign cfg_wr      = cfg_req.write;

  // ---- base registers
  logic [31:0] io_rdata;
  logic [31:0] mem_rdata;
  logic        io_match;
  logic        mem_match;
  logic [31:0] mem_base_raw;

  pibad_bar #(
    .IS_IO     (1'b1),
    .SIZE_LOG2 (IO_SIZE_LOG2),
    .PREFETCH  (PIBAD_PREFETCH_OFF)
  ) u_io_bar (
    .mclk  (mclk),
    .rst_n (rst_n),
    .ce    (ce),
    .wr_en (cfg_take && cfg_wr && sel_io),
    .be    (cfg_req.be),
    .wdata (cfg_req.wdata),
    .addr  (addr_req.addr),
    .rdata (io_rdata),
    .base  (io_base),
    .match (io_match)
  );

  // same control longword also reachable in memory space
  pibad_bar #(
    .IS_IO     (1'b0),
    .SIZE_LOG2 (MEM_SIZE_LOG2),
    .PREFETCH  (PIBAD_PREFETCH_OFF)
  ) u_mem_bar (
    .mclk  (mclk),
    .rst_n (rst_n),
    .ce    (ce),
    .wr_en (cfg_take && cfg_wr && sel_mem),
    .be    (cfg_req.be),
    .wdata (cfg_req.wdata),
    .addr  (addr_req.addr),
    .rdata (mem_rdata),
    .base  (mem_base_raw),
    .match (mem_match)
  );

  assign mem_base = MEM_BAR_EN ? mem_base_raw : PIBAD_BAR_RST;

  // ---- config readback
  wire [31:0] cfg_rd_sel;
  wire        cfg_owned;

  // first slot and unused slots read zero from this block
  assign cfg_rd_sel = sel_io  ? io_rdata  :
                      sel_mem ? mem_rdata :
                                PIBAD_BAR_RST;
  assign cfg_owned  = cfg_in_bars && !sel_first;

  pibad_cfg_rsp_type cfg_rsp_r;
  pibad_cfg_rsp_type cfg_rsp_nxt;

  always_comb begin
    cfg_rsp_nxt       = '0;
    cfg_rsp_nxt.valid = cfg_req.valid;
    cfg_rsp_nxt.owned = cfg_req.valid && cfg_owned;
    cfg_rsp_nxt.rdata = (cfg_req.valid && !cfg_wr) ? cfg_rd_sel : PIBAD_BAR_RST;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rsp_r <= '0;
    end else if (ce) begin
      cfg_rsp_r <= cfg_rsp_nxt;
    end
  end

  assign cfg_rsp = cfg_rsp_r;

  // ---- address claim
  wire       io_hit;
  wire       mem_hit;
  wire [1:0] lane;
  wire       csr_sel;

  assign io_hit  = addr_req.valid && addr_req.is_io && io_space_en && io_match;
  assign mem_hit = MEM_BAR_EN && addr_req.valid && addr_req.is_mem
                   && mem_space_en && mem_match;
  // only bits 1:0 reach the register; bits 5:2 are ignored so all longwords alias
  assign lane    = addr_req.addr[1:0];
  assign csr_sel = addr_req.addr[PIBAD_CSR_SEL_BIT];

  pibad_claim_type claim_r;
  pibad_claim_type claim_nxt;

  always_comb begin
    claim_nxt         = '0;
    claim_nxt.valid   = addr_req.valid;
    claim_nxt.io_hit  = io_hit;
    claim_nxt.mem_hit = mem_hit;
    claim_nxt.csr_sel = (io_hit || mem_hit) && csr_sel;
    claim_nxt.lane    = (io_hit || mem_hit) ? lane : 2'b00;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      claim_r <= '0;
    end else if (ce) begin
      claim_r <= claim_nxt;
    end
  end

  assign claim = claim_r;

endmodule : pibad_top
`default_nettype wire

// *** bench/pibad_top_asserts.sv ***
// Purpose: port checks for the base register and window decode
// Assumes: single clock domain, ce high when requests are judged
// Notes:   bound to pibad_top below
`timescale 1ns/1ps
`default_nettype none
module pibad_asserts
  import pibad_pkg::*;
(
  input wire logic               mclk,
  input wire logic               rst_n,
  input wire logic               ce,
  input wire logic               io_space_en,
  input wire logic               mem_space_en,
  input wire pibad_cfg_req_type  cfg_req,
  input wire pibad_cfg_rsp_type  cfg_rsp,
  input wire pibad_addr_req_type addr_req,
  input wire pibad_claim_type    claim,
  input wire logic [31:0]        io_base,
  input wire logic [31:0]        mem_base
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire logic       cv     = ce && cfg_req.valid;
  wire logic       rd     = cv && !cfg_req.write;
  wire logic       av     = ce && addr_req.valid;
  wire logic [1:0] lane_i = addr_req.addr[1:0];
  wire logic       io_ok  = addr_req.is_io && io_space_en && addr_req.addr[31:6] == io_base[31:6];
  a_rsp_follows_req: assert property (cv |=> cfg_rsp.valid) else $error("config answer missing");
  a_rsp_idle: assert property (ce && !cfg_req.valid |=> !cfg_rsp.valid) else $error("stray answer");
  a_io_low_zero: assert property (io_base[5:0] == 6'h00) else $error("io base low bits set");
  a_mem_low_zero: assert property (mem_base[5:0] == 6'h00) else $error("mem base low bits set");
  a_bridge_slot_free: assert property (cv && cfg_req.offset == 8'h10 |=> !cfg_rsp.owned && cfg_rsp.rdata == 32'h0)
    else $error("bridge slot answered");
  a_io_bar_read: assert property (rd && cfg_req.offset == 8'h14 |=> cfg_rsp.rdata == ($past(io_base) | 32'h1))
    else $error("io base read wrong");
  a_mem_bar_read: assert property (rd && cfg_req.offset == 8'h18 |=> cfg_rsp.rdata == $past(mem_base))
    else $error("mem base read wrong");
  a_io_hit_lane: assert property (av && io_ok |=> claim.valid && claim.io_hit && claim.lane == $past(lane_i))
    else $error("io hit or lane wrong");
  a_io_miss: assert property (av && !io_ok |=> !claim.io_hit) else $error("io claimed wrongly");
  cover property (av && io_ok);
  cover property (cv && cfg_req.write && cfg_req.offset == 8'h14);
  cover property (av && addr_req.is_mem && mem_space_en);
endmodule : pibad_asserts
bind pibad_top pibad_asserts pibad_asserts_inst (.mclk(mclk), .rst_n(rst_n), .ce(ce), .io_space_en(io_space_en),
  .mem_space_en(mem_space_en), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .addr_req(addr_req), .claim(claim),
  .io_base(io_base), .mem_base(mem_base));
`default_nettype wire

// *** bench/pibad_host_model.sv ***
// Purpose: host side issuing config and address phases
// Assumes: tasks are entered just after a rising edge
// Notes:   idle fields are scrambled so stale values never help
`timescale 1ns/1ps
`default_nettype none
module pibad_host_model
  import pibad_pkg::*;
(
  input  wire logic          mclk,
  output var pibad_cfg_req_type  cfg_req,
  output var pibad_addr_req_type addr_req
);
  initial begin
    cfg_req  = '0;
    addr_req = '0;
  end
  task automatic cfg(input logic w, input logic [7:0] off, input logic [31:0] d);
    cfg_req        <= '{1'b1, w, off, 4'hf, d};
    addr_req.valid <= 1'b0;
    @(posedge mclk);
  endtask : cfg
  task automatic acc(input logic io, input logic [31:0] a);
    addr_req      <= '{1'b1, io, ~io, a};
    cfg_req.valid <= 1'b0;
    @(posedge mclk);
  endtask : acc
  task automatic idle;
    cfg_req.valid  <= 1'b0;
    cfg_req.wdata  <= ~cfg_req.wdata;
    addr_req.valid <= 1'b0;
    addr_req.addr  <= ~addr_req.addr;
    @(posedge mclk);
  endtask : idle
endmodule : pibad_host_model
`default_nettype wire

// *** bench/pibad_top_tb.sv ***
// Purpose: self-checking bench for base register access and window claim
// Assumes: ce held high
// Notes:   expectations queued by the driver, checked by a monitor
`timescale 1ns/1ps
`default_nettype none
module pibad_top_tb;
  import pibad_pkg::*;
  logic               mclk, rst_n, ce, io_space_en, mem_space_en;
  pibad_cfg_req_type  cfg_req;
  pibad_cfg_rsp_type  cfg_rsp;
  pibad_addr_req_type addr_req;
  pibad_claim_type    claim, clm_e;
  logic [31:0]        io_base, mem_base, a, r;
  logic [32:0]        cfg_q[$], cfg_e;
  pibad_claim_type    clm_q[$];
  int                 failures, checks_done, seed, i;
  logic               io;
  always #4 mclk = ~mclk;
  pibad_top pibad_top_inst (.mclk(mclk), .rst_n(rst_n), .ce(ce), .io_space_en(io_space_en),
    .mem_space_en(mem_space_en), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .addr_req(addr_req), .claim(claim),
    .io_base(io_base), .mem_base(mem_base));
  pibad_host_model pibad_host_model_inst (.mclk(mclk), .cfg_req(cfg_req), .addr_req(addr_req));
  task automatic check(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic cfg(input logic w, input logic [7:0] off, input logic [31:0] d, input logic own, input logic [31:0] e);
    cfg_q.push_back({own, e});
    pibad_host_model_inst.cfg(w, off, d);
  endtask : cfg
  task automatic acc(input logic io, input logic [31:0] a, input logic hit);
    clm_q.push_back('{1'b1, hit & io, hit & ~io, hit & a[1], hit ? a[1:0] : 2'b00});
    pibad_host_model_inst.acc(io, a);
  endtask : acc
  task automatic final_report;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  always @(negedge mclk) begin
    if (cfg_rsp.valid === 1'b1) begin
      cfg_e = cfg_q.size() > 0 ? cfg_q.pop_front() : 'x;
      check("cfg_rsp", {cfg_rsp.owned, cfg_rsp.rdata}, cfg_e);
    end
    if (claim.valid === 1'b1) begin
      clm_e = clm_q.size() > 0 ? clm_q.pop_front() : 'x;
      check("claim", claim, clm_e);
    end
  end
  initial begin
    seed = 83;
    mclk = 1'b0;
    rst_n = 1'b0;
    ce = 1'b1;
    io_space_en = 1'b0;
    mem_space_en = 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    check("io_base", io_base, 0);
    cfg(0, 8'h14, 0, 1, 32'h1);
    cfg(1, 8'h14, '1, 1, 0);
    cfg(0, 8'h14, 0, 1, 32'hffffffc1);
    cfg(1, 8'h18, '1, 1, 0);
    cfg(0, 8'h18, 0, 1, 32'hffffffc0);
    cfg(1, 8'h10, '1, 0, 0);
    cfg(0, 8'h10, 0, 0, 0);
    cfg(1, 8'h14, 32'h0000fbc0, 1, 0);
    cfg(1, 8'h18, 32'h12345640, 1, 0);
    pibad_host_model_inst.idle();
    for (i = 0; i < 60; i++) begin
      r = $random(seed);
      io = r[6];
      a = r[7] ? {(io ? 26'h3ef : 26'h48d159), r[5:0]} : (r[10] ? r ^ 32'h40 : r);
      io_space_en <= r[8];
      mem_space_en <= r[9];
      acc(io, a, (io ? r[8] : r[9]) && a[31:6] == (io ? 26'h3ef : 26'h48d159));
    end
    pibad_host_model_inst.idle();
    for (i = 0; i < 20 && (cfg_q.size() || clm_q.size()); i++) @(posedge mclk);
    check("queue", cfg_q.size() + clm_q.size(), 0);
    final_report();
  end
endmodule : pibad_top_tb
`default_nettype wire
